// >>> rtl/fsog_consts.svh
`ifndef FSOG_CONSTS_SVH
`define FSOG_CONSTS_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define FSOG_ADDR_OUT_CTRL4   8'h00
`define FSOG_ADDR_FS_CTRL1    8'h04
`define FSOG_ADDR_OC3_DIV     8'h08
`define FSOG_ADDR_STATUS      8'h0C
`define FSOG_ADDR_SYNTH_BASE  8'h10
`define FSOG_ADDR_OUT_BASE    8'h30

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define FSOG_BIT_FS_EN        0
`define FSOG_BIT_MFS_EN       1
`define FSOG_BIT_FS_PUL       0
`define FSOG_BIT_FS_INV       1
`define FSOG_BIT_MFS_PUL      2
`define FSOG_BIT_MFS_INV      3

// ---------------------------------------------------------------
// Reset values and timing
// ---------------------------------------------------------------
`define FSOG_RST_CTRL         2'h0
`define FSOG_RST_FSCR         4'h0
`define FSOG_RST_OC3_DIV      16'h0001
`define FSOG_OC3_RATE_KHZ     1544
`define FSOG_FRAME_US         125
`define FSOG_MFRAME_US        500
`define FSOG_STD_MAX_2K       38880
`define FSOG_STD_MAX_8K       38880
`define FSOG_ANALOG_MULTIPLIER_LOOP_MAX_KHZ     77760

`endif

// >>> rtl/fsog_out_check.sv
`timescale 1ns/1ps
`default_nettype none
`include "fsog_consts.svh"

module fsog_out_check
    import fsog_pkg::*;
(
    input  wire logic [2:0] out_index,
    input  wire logic [2:0] freq_sel,
    input  wire logic [1:0] src_sel,
    input  wire logic [7:0] sub_div,
    output logic            legal
);

    // ---------------------------------------------------------------
    // Frequency and path legality
    // ---------------------------------------------------------------
    always_comb begin
        legal = (sub_div != 8'h00);
        case (freq_sel)
            // Outputs four to seven, second path
            FSOG_F_156M25, FSOG_F_312M5: begin
                legal = legal && (out_index >= 3'h3) && (src_sel == FSOG_SRC_MAIN_APLL2);
            end
            // Not low outputs from main loop
            FSOG_F_131M072, FSOG_F_148M224: begin
                if (src_sel == FSOG_SRC_SEC_ANALOG_MULTIPLIER_LOOP) begin
                    legal = legal && (out_index >= 3'h5);
                end else begin
                    legal = legal && (out_index >= 3'h3) && (src_sel != FSOG_SRC_MAIN_DIRECT);
                end
            end
            FSOG_F_125M, FSOG_F_155M52: begin
                if (src_sel == FSOG_SRC_SEC_ANALOG_MULTIPLIER_LOOP) begin
                    legal = legal && (out_index >= 3'h2);
                end else begin
                    legal = legal && (out_index >= 3'h3) && (src_sel == FSOG_SRC_MAIN_APLL2);
                end
            end
            FSOG_F_CUSTOM: begin
                legal = legal;
            end
            default: begin
                legal = 1'b0;
            end
        endcase
    end

endmodule : fsog_out_check
`default_nettype wire

// >>> rtl/fsog_pkg.sv
package fsog_pkg;

    typedef enum logic [1:0] {
        FSOG_SRC_MAIN_DIRECT = 2'b00,
        FSOG_SRC_MAIN_ANALOG_MULTIPLIER_LOOP   = 2'b01,
        FSOG_SRC_MAIN_APLL2  = 2'b10,
        FSOG_SRC_SEC_ANALOG_MULTIPLIER_LOOP    = 2'b11
    } fsog_src_t;

    typedef enum logic [2:0] {
        FSOG_F_CUSTOM  = 3'h0,
        FSOG_F_156M25  = 3'h1,
        FSOG_F_312M5   = 3'h2,
        FSOG_F_131M072 = 3'h3,
        FSOG_F_148M224 = 3'h4,
        FSOG_F_125M    = 3'h5,
        FSOG_F_155M52  = 3'h6
    } fsog_freq_t;

    typedef enum logic [0:0] {
        FSOG_ST_RUN  = 1'b0,
        FSOG_ST_HOLD = 1'b1
    } fsog_state_t;

endpackage : fsog_pkg

// >>> rtl/fsog_top.sv
// Function
// - Frame sync output driven only while its enable bit is one
// - Multiframe sync output driven only while its enable bit is one
// - Disabled sync output held low
// - Frame sync clock mode gives an 8kHz square wave
// - Frame sync pulse mode gives one low clock-three cycle per 125us
// - Frame sync invert flips clock and pulse forms
// - Multiframe clock mode gives a 2kHz square wave
// - Multiframe pulse mode gives one low clock-three cycle per 500us
// - Multiframe invert flips clock and pulse forms
// - Each of seven synthesizers may take a custom frequency
// - Custom frequency: multiple of 2kHz up to 77.76MHz
// - Custom frequency: multiple of 8kHz up to 311.04MHz
// - Each output carries the custom frequency or a submultiple
// - 156.25 and 312.5MHz only on outputs four to seven, second path
// - 131.072 and 148.224MHz: restricted outputs per loop
// - 125 and 155.52MHz use divide by two; not outputs one, two from secondary
`timescale 1ns/1ps
`default_nettype none
`include "fsog_consts.svh"

module fsog_top
    import fsog_pkg::*;
#(
    parameter int OC3_KHZ = `FSOG_OC3_RATE_KHZ,
    parameter int N_OUT   = 7
) (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    output logic             frame_sync_out,
    output logic             multiframe_sync_out
);

    // ---------------------------------------------------------------
    // Constants
    // ---------------------------------------------------------------
    localparam int FRAME_CYC  = (OC3_KHZ * `FSOG_FRAME_US) / 1000;
    localparam int MFRAME_CYC = (OC3_KHZ * `FSOG_MFRAME_US) / 1000;
    localparam logic [15:0] FRAME_LAST = 16'(FRAME_CYC - 1);
    localparam logic [15:0] FRAME_HALF = 16'(FRAME_CYC / 2);

    if (OC3_KHZ < `FSOG_OC3_RATE_KHZ || FRAME_CYC > 65535 || N_OUT != 7) begin : g_bad_param
        $error("fsog_top: unsupported parameters");
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    logic [1:0]  ctrl_q, ctrl_d;
    logic [3:0]  fscr_q, fscr_d;
    logic [15:0] ocdiv_q, ocdiv_d;
    logic [31:0] synth_q [0:6];
    logic [31:0] synth_d [0:6];
    logic [12:0] outc_q [0:6];
    logic [12:0] outc_d [0:6];
    logic [31:0] rdata_q, rdata_d;
    logic [6:0]  legal_v;
    logic [6:0]  cust_ok;

    function automatic logic custom_ok(input logic [31:0] cfg);
        logic [19:0] khz;
        logic        is8k;
        logic        analog_multiplier_loop;
        khz  = cfg[19:0];
        is8k = cfg[20];
        analog_multiplier_loop = cfg[21];
        custom_ok = (khz != 20'h00000);
        if (!is8k) begin
            custom_ok = custom_ok && (khz[0] == 1'b0) && (khz <= 20'(`FSOG_ANALOG_MULTIPLIER_LOOP_MAX_KHZ));
        end else begin
            custom_ok = custom_ok && (khz[2:0] == 3'h0) && (khz <= 20'h4BF00);
        end
        if (khz > 20'(`FSOG_ANALOG_MULTIPLIER_LOOP_MAX_KHZ)) begin
            custom_ok = custom_ok && analog_multiplier_loop;
        end
    endfunction : custom_ok

    for (genvar g = 0; g < 7; g++) begin : g_out
        assign cust_ok[g] = custom_ok(synth_q[g]);
        fsog_out_check u_chk (
            .out_index (3'(g)),
            .freq_sel  (outc_q[g][2:0]),
            .src_sel   (outc_q[g][4:3]),
            .sub_div   (outc_q[g][12:5]),
            .legal     (legal_v[g])
        );
    end

    always_comb begin
        ctrl_d  = ctrl_q;
        fscr_d  = fscr_q;
        ocdiv_d = ocdiv_q;
        rdata_d = 32'h00000000;
        for (int i = 0; i < 7; i++) begin
            synth_d[i] = synth_q[i];
            outc_d[i]  = outc_q[i];
        end
        if (reg_wr) begin
            if (reg_addr == `FSOG_ADDR_OUT_CTRL4) begin
                ctrl_d = reg_wdata[1:0];
            end else if (reg_addr == `FSOG_ADDR_FS_CTRL1) begin
                fscr_d = reg_wdata[3:0];
            end else if (reg_addr == `FSOG_ADDR_OC3_DIV) begin
                ocdiv_d = reg_wdata[15:0];
            end else if (reg_addr >= `FSOG_ADDR_SYNTH_BASE && reg_addr < 8'h2C
                         && reg_addr[1:0] == 2'h0) begin
                synth_d[3'(reg_addr[4:2] - 3'h4)] = {10'h000, reg_wdata[21:0]};
            end else if (reg_addr >= `FSOG_ADDR_OUT_BASE && reg_addr < 8'h4C
                         && reg_addr[1:0] == 2'h0) begin
                outc_d[3'((reg_addr - 8'h30) >> 2)] = reg_wdata[12:0];
            end
        end
        if (reg_rd) begin
            if (reg_addr == `FSOG_ADDR_OUT_CTRL4) begin
                rdata_d = {30'h00000000, ctrl_q};
            end else if (reg_addr == `FSOG_ADDR_FS_CTRL1) begin
                rdata_d = {28'h0000000, fscr_q};
            end else if (reg_addr == `FSOG_ADDR_OC3_DIV) begin
                rdata_d = {16'h0000, ocdiv_q};
            end else if (reg_addr == `FSOG_ADDR_STATUS) begin
                rdata_d = {16'h0000, 1'b0, cust_ok, 1'b0, legal_v};
            end else if (reg_addr >= `FSOG_ADDR_SYNTH_BASE && reg_addr < 8'h2C
                         && reg_addr[1:0] == 2'h0) begin
                rdata_d = synth_q[3'(reg_addr[4:2] - 3'h4)];
            end else if (reg_addr >= `FSOG_ADDR_OUT_BASE && reg_addr < 8'h4C
                         && reg_addr[1:0] == 2'h0) begin
                rdata_d = {19'h00000, outc_q[3'((reg_addr - 8'h30) >> 2)]};
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q  <= `FSOG_RST_CTRL;
            fscr_q  <= `FSOG_RST_FSCR;
            ocdiv_q <= `FSOG_RST_OC3_DIV;
            rdata_q <= 32'h00000000;
            for (int i = 0; i < 7; i++) begin
                synth_q[i] <= 32'h00000000;
                outc_q[i]  <= 13'h0020;
            end
        end else begin
            ctrl_q  <= ctrl_d;
            fscr_q  <= fscr_d;
            ocdiv_q <= ocdiv_d;
            rdata_q <= rdata_d;
            for (int i = 0; i < 7; i++) begin
                synth_q[i] <= synth_d[i];
                outc_q[i]  <= outc_d[i];
            end
        end
    end

    assign reg_rdata = rdata_q;

    // ---------------------------------------------------------------
    // Clock three tick and shared counters
    // ---------------------------------------------------------------
    logic [15:0] pre_q, pre_d;
    logic [15:0] fcnt_q, fcnt_d;
    logic [1:0]  mcnt_q, mcnt_d;
    logic        fs_q, fs_d, mfs_q, mfs_d;
    logic        tick;
    logic        fs_raw, mfs_raw;

    assign tick = (pre_q >= ocdiv_q - 16'h0001) || (ocdiv_q == 16'h0000);

    always_comb begin
        pre_d  = tick ? 16'h0000 : 16'(pre_q + 16'h0001);
        fcnt_d = fcnt_q;
        mcnt_d = mcnt_q;
        if (tick) begin
            if (fcnt_q >= FRAME_LAST) begin
                fcnt_d = 16'h0000;
                mcnt_d = 2'(mcnt_q + 2'h1);
            end else begin
                fcnt_d = 16'(fcnt_q + 16'h0001);
            end
        end
        if (!fscr_q[`FSOG_BIT_FS_PUL]) begin
            fs_raw = (fcnt_d < FRAME_HALF);
        end else begin
            fs_raw = !(fcnt_d == 16'h0000);
        end
        if (!fscr_q[`FSOG_BIT_MFS_PUL]) begin
            mfs_raw = !mcnt_d[1];
        end else begin
            mfs_raw = !(fcnt_d == 16'h0000 && mcnt_d == 2'h0);
        end
        fs_raw = fs_raw ^ fscr_q[`FSOG_BIT_FS_INV];
        mfs_raw = mfs_raw ^ fscr_q[`FSOG_BIT_MFS_INV];
        fs_d = ctrl_q[`FSOG_BIT_FS_EN] && fs_raw;
        mfs_d = ctrl_q[`FSOG_BIT_MFS_EN] && mfs_raw;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_q  <= 16'h0000;
            fcnt_q <= 16'h0000;
            mcnt_q <= 2'h0;
            fs_q   <= 1'b0;
            mfs_q  <= 1'b0;
        end else begin
            pre_q  <= pre_d;
            fcnt_q <= fcnt_d;
            mcnt_q <= mcnt_d;
            fs_q   <= fs_d;
            mfs_q  <= mfs_d;
        end
    end

    assign frame_sync_out      = fs_q;
    assign multiframe_sync_out = mfs_q;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    a_fs_disabled_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !$past(ctrl_q[`FSOG_BIT_FS_EN]) |-> !frame_sync_out)
        else $error("frame sync high while disabled");
    a_mfs_disabled_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !$past(ctrl_q[`FSOG_BIT_MFS_EN]) |-> !multiframe_sync_out)
        else $error("multiframe sync high while disabled");
    a_fs_pulse_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (ctrl_q[0] && $stable(ctrl_q) && fscr_q[1:0] == 2'b01 && $stable(fscr_q)
         && fcnt_q == 16'h0000) |-> frame_sync_out == 1'b0)
        else $error("frame pulse missing");
    a_fs_pulse_high: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (ctrl_q[0] && $stable(ctrl_q) && fscr_q[1:0] == 2'b01 && $stable(fscr_q)
         && fcnt_q != 16'h0000) |-> frame_sync_out == 1'b1)
        else $error("frame pulse outside slot");
    a_fs_invert_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (ctrl_q[0] && $stable(ctrl_q) && fscr_q[1:0] == 2'b11 && $stable(fscr_q)
         && fcnt_q == 16'h0000) |-> frame_sync_out == 1'b1)
        else $error("frame invert wrong");
    a_fs_clock_half: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (ctrl_q[0] && $stable(ctrl_q) && fscr_q[1:0] == 2'b00 && $stable(fscr_q)
         && fcnt_q == 16'h0001) |-> frame_sync_out == 1'b1)
        else $error("frame clock phase wrong");
    a_mfs_pulse_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (ctrl_q[1] && $stable(ctrl_q) && fscr_q[3:2] == 2'b01 && $stable(fscr_q)
         && fcnt_q == 16'h0000 && mcnt_q == 2'h0) |-> multiframe_sync_out == 1'b0)
        else $error("multiframe pulse missing");
    a_mfs_clock_phase: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (ctrl_q[1] && $stable(ctrl_q) && fscr_q[3:2] == 2'b00 && $stable(fscr_q)
         && mcnt_q == 2'h2 && fcnt_q == 16'h0005) |-> multiframe_sync_out == 1'b0)
        else $error("multiframe clock phase wrong");
    a_mfs_invert: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (ctrl_q[1] && $stable(ctrl_q) && fscr_q[3:2] == 2'b11 && $stable(fscr_q)
         && fcnt_q == 16'h0000 && mcnt_q == 2'h0) |-> multiframe_sync_out == 1'b1)
        else $error("multiframe invert wrong");
    a_counter_wrap: assert property (@(posedge ref_clk) disable iff (!rst_n)
        fcnt_q <= FRAME_LAST)
        else $error("frame counter overrun");
    c_fs_pulse: cover property (@(posedge ref_clk) disable iff (!rst_n)
        fscr_q[0] && $fell(frame_sync_out));
    c_mfs_pulse: cover property (@(posedge ref_clk) disable iff (!rst_n)
        fscr_q[2] && $fell(multiframe_sync_out));
    c_fs_clock: cover property (@(posedge ref_clk) disable iff (!rst_n)
        !fscr_q[0] && $rose(frame_sync_out));
    c_out_legal: cover property (@(posedge ref_clk) disable iff (!rst_n) legal_v[6]);

endmodule : fsog_top
`default_nettype wire

// >>> test/fsog_sync_monitor.sv
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// Framer-side run length monitor
// ---------------------------------------------------------------
module fsog_sync_monitor (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        sig,
    output logic      [15:0] high_len,
    output logic      [15:0] low_len,
    output logic      [15:0] edge_cnt
);
    logic        last_q;
    logic [15:0] run_q;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            last_q   <= 1'b0;
            run_q    <= 16'h0000;
            high_len <= 16'h0000;
            low_len  <= 16'h0000;
            edge_cnt <= 16'h0000;
        end else if (sig !== last_q) begin
            if (last_q) begin
                high_len <= run_q;
            end else begin
                low_len <= run_q;
            end
            last_q   <= sig;
            run_q    <= 16'h0001;
            edge_cnt <= edge_cnt + 16'h0001;
        end else begin
            run_q <= run_q + 16'h0001;
        end
    end
endmodule : fsog_sync_monitor

`default_nettype wire

// >>> test/fsog_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "fsog_consts.svh"

module fsog_tb_top
    import fsog_pkg::*;
;
    localparam int FT = `FSOG_OC3_RATE_KHZ * `FSOG_FRAME_US / 1000;
    localparam int MT = FT * `FSOG_MFRAME_US / `FSOG_FRAME_US;

    logic        ref_clk;
    logic        rst_n;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic        frame_sync_out;
    logic        multiframe_sync_out;
    logic [15:0] fs_hi, fs_lo, fs_edges, mf_hi, mf_lo, mf_edges;
    logic [31:0] rd_val;
    int          bad_count;
    int          n_checks;
    int          i;

    always #2 ref_clk = ~ref_clk;

    fsog_top #(.OC3_KHZ(`FSOG_OC3_RATE_KHZ), .N_OUT(7)) uut (
        .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .frame_sync_out(frame_sync_out), .multiframe_sync_out(multiframe_sync_out));
    fsog_sync_monitor mon_fs (.ref_clk(ref_clk), .rst_n(rst_n), .sig(frame_sync_out),
        .high_len(fs_hi), .low_len(fs_lo), .edge_cnt(fs_edges));
    fsog_sync_monitor mon_mf (.ref_clk(ref_clk), .rst_n(rst_n), .sig(multiframe_sync_out),
        .high_len(mf_hi), .low_len(mf_lo), .edge_cnt(mf_edges));

    // ---------------------------------------------------------------
    // Bench tasks
    // ---------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd_raw(input logic [7:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        rd_val = reg_rdata;
    endtask : rd_raw

    task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
        rd_raw(a);
        check(name, rd_val, exp);
    endtask : rd

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : tick

    task automatic path_case(input int idx, input fsog_freq_t f, input fsog_src_t s,
                             input logic exp);
        wr(`FSOG_ADDR_OUT_BASE + 8'(idx * 4), {19'h0, 8'h01, s, f});
        rd_raw(`FSOG_ADDR_STATUS);
        check("status spare", 32'({rd_val[31:15], rd_val[7]}), 32'h0);
        check("path legal", 32'(rd_val[idx]), 32'(exp));
    endtask : path_case

    task automatic synth_case(input int idx, input logic [19:0] khz, input logic k8,
                              input logic m, input logic exp);
        wr(`FSOG_ADDR_SYNTH_BASE + 8'(idx * 4), {10'h0, m, k8, khz});
        rd_raw(`FSOG_ADDR_STATUS);
        @(negedge ref_clk);
        check("rdata idle", reg_rdata, 32'h0);
        check("custom ok", 32'(rd_val[8 + idx]), 32'(exp));
    endtask : synth_case

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        ref_clk   = 1'b0;
        rst_n     = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 32'h0000_0000;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        bad_count = 0;
        n_checks  = 0;
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(negedge ref_clk);
        check("fs at reset", 32'(frame_sync_out), 32'h0);
        rd("ctrl4", `FSOG_ADDR_OUT_CTRL4, 32'h0);
        rd("frame_sync_control_one", `FSOG_ADDR_FS_CTRL1, 32'h0);
        rd("divider", `FSOG_ADDR_OC3_DIV, 32'h1);
        rd("unmapped", 8'hFC, 32'h0);
        $display("test reset done");
        wr(`FSOG_ADDR_FS_CTRL1, 32'hA);
        tick(900);
        check("fs edges off", 32'(fs_edges), 32'h0);
        check("mf low off", 32'(multiframe_sync_out), 32'h0);
        wr(`FSOG_ADDR_FS_CTRL1, 32'h0);
        wr(`FSOG_ADDR_OUT_CTRL4, 32'h1);
        tick(1700);
        check("mf edges", 32'(mf_edges), 32'h0);
        check("fs period", 32'(fs_hi + fs_lo), 32'(FT));
        $display("test enable done");
        wr(`FSOG_ADDR_OUT_CTRL4, 32'h3);
        tick(1700);
        check("fs half", 32'(fs_hi == 16'(FT / 2) || fs_hi == 16'(FT / 2 + 1)), 32'h1);
        check("fs period", 32'(fs_hi + fs_lo), 32'(FT));
        check("mf high", 32'(mf_hi), 32'(MT / 2));
        check("mf low", 32'(mf_lo), 32'(MT / 2));
        rd("ctrl4", `FSOG_ADDR_OUT_CTRL4, 32'h3);
        $display("test clock mode done");
        wr(`FSOG_ADDR_FS_CTRL1, 32'h5);
        tick(1700);
        check("fs pulse", 32'(fs_lo), 32'h1);
        check("fs gap", 32'(fs_hi), 32'(FT - 1));
        check("mf pulse", 32'(mf_lo), 32'h1);
        check("mf gap", 32'(mf_hi), 32'(MT - 1));
        for (i = 0; i < 2000 && multiframe_sync_out !== 1'b0; i++) begin
            @(negedge ref_clk);
        end
        if (i == 2000) begin
            bad_count++;
            report_and_stop();
        end
        check("pulses aligned", 32'(frame_sync_out), 32'h0);
        $display("test pulse mode done");
        wr(`FSOG_ADDR_FS_CTRL1, 32'hF);
        tick(1700);
        check("fs inv pulse", 32'(fs_hi), 32'h1);
        check("fs inv gap", 32'(fs_lo), 32'(FT - 1));
        check("mf inv pulse", 32'(mf_hi), 32'h1);
        check("mf inv gap", 32'(mf_lo), 32'(MT - 1));
        $display("test invert done");
        wr(`FSOG_ADDR_OC3_DIV, 32'h2);
        wr(`FSOG_ADDR_FS_CTRL1, 32'h5);
        tick(3300);
        check("fs slow pulse", 32'(fs_lo), 32'h2);
        check("fs slow gap", 32'(fs_hi), 32'(2 * FT - 2));
        check("mf slow pulse", 32'(mf_lo), 32'h2);
        check("mf slow gap", 32'(mf_hi), 32'(2 * MT - 2));
        $display("test divider done");
        path_case(0, FSOG_F_156M25, FSOG_SRC_MAIN_APLL2, 1'b0);
        path_case(3, FSOG_F_156M25, FSOG_SRC_MAIN_APLL2, 1'b1);
        path_case(3, FSOG_F_156M25, FSOG_SRC_MAIN_ANALOG_MULTIPLIER_LOOP, 1'b0);
        path_case(6, FSOG_F_312M5, FSOG_SRC_MAIN_APLL2, 1'b1);
        path_case(0, FSOG_F_131M072, FSOG_SRC_MAIN_ANALOG_MULTIPLIER_LOOP, 1'b0);
        path_case(5, FSOG_F_131M072, FSOG_SRC_SEC_ANALOG_MULTIPLIER_LOOP, 1'b1);
        path_case(3, FSOG_F_148M224, FSOG_SRC_SEC_ANALOG_MULTIPLIER_LOOP, 1'b0);
        path_case(0, FSOG_F_125M, FSOG_SRC_SEC_ANALOG_MULTIPLIER_LOOP, 1'b0);
        path_case(3, FSOG_F_155M52, FSOG_SRC_MAIN_APLL2, 1'b1);
        path_case(3, FSOG_F_125M, FSOG_SRC_MAIN_ANALOG_MULTIPLIER_LOOP, 1'b0);
        path_case(1, FSOG_F_CUSTOM, FSOG_SRC_MAIN_DIRECT, 1'b1);
        synth_case(0, 20'h12FC0, 1'b0, 1'b0, 1'b1);
        synth_case(1, 20'h12FC2, 1'b0, 1'b1, 1'b0);
        synth_case(2, 20'h4BF00, 1'b1, 1'b1, 1'b1);
        synth_case(3, 20'h4BF08, 1'b1, 1'b1, 1'b0);
        synth_case(4, 20'h00064, 1'b1, 1'b1, 1'b0);
        synth_case(5, 20'h4BF00, 1'b1, 1'b0, 1'b0);
        synth_case(6, 20'h12FC0, 1'b0, 1'b0, 1'b1);
        $display("test status done");
        wr(`FSOG_ADDR_OUT_CTRL4, 32'h0);
        tick(10);
        check("fs off", 32'(frame_sync_out), 32'h0);
        check("mf off", 32'(multiframe_sync_out), 32'h0);
        $display("test disable done");
        report_and_stop();
    end
endmodule : fsog_tb_top

`default_nettype wire
